// *** hw/osd_char_ctrl.sv ***
`timescale 1ns/1ps
module osd_char_ctrl
  import osd_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic [2:0]             cpuAddr,
  input  wire logic                   cpuWr,
  input  wire logic [7:0]             cpuWrData,
  output logic      [7:0]             cpuRdData,
  input  wire logic                   horizontalSyncIn_b,
  input  wire logic                   verticalSyncIn_b,
  input  wire logic                   lastScanLine,
  input  wire logic                   fullRasterBlankEnable,
  input  wire logic [`OSD_ADDR_W-1:0] dispRdAddr,
  input  wire logic                   charAreaActive,
  input  wire logic                   patternPixel,
  input  wire logic                   fringePixel,
  input  wire logic [3:0]             portLatch,
  output logic      [`OSD_CODE_W-1:0] dispCode,
  output logic      [3:0]             pinOut,
  output logic                        osdIrq
);
  osd_top_t s;
  osd_top_t next_s;

  logic [1:0]             syncFall;
  logic                   hsFall;
  logic                   vsFall;
  logic                   memCodeWe;
  logic                   memAttrWe;
  logic [`OSD_CODE_W-1:0] rdCode;
  logic [`OSD_ATTR_W-1:0] rdAttr;
  logic                   wrAttr;
  logic                   wrCode;
  logic                   bankCombined;

  // ==================================================
  // Sync inputs
  osd_edge_sync u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .syncIn_b ({verticalSyncIn_b, horizontalSyncIn_b}),
    .syncFall (syncFall)
  );

  assign hsFall = syncFall[0];
  assign vsFall = syncFall[1];

  // ==================================================
  // Display memory write strobes
  assign wrAttr       = cpuWr && (cpuAddr == `OSD_OFF_ATTR);
  assign wrCode       = cpuWr && (cpuAddr == `OSD_OFF_CODE);
  assign bankCombined = s.miscReg[`OSD_MISC_BANK];
  assign memAttrWe    = wrAttr || (wrCode && bankCombined);
  assign memCodeWe    = wrCode;

  osd_disp_mem u_mem (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .codeWe  (memCodeWe),
    .attrWe  (memAttrWe),
    .wrAddr  (s.dispAddr),
    .codeIn  (cpuWrData),
    .attrIn  (wrAttr ? cpuWrData[`OSD_ATTR_W-1:0] : s.attrReg[`OSD_ATTR_W-1:0]),
    .rdAddr  (dispRdAddr),
    .rdCode  (rdCode),
    .rdAttr  (rdAttr)
  );

  // ==================================================
  // Next-state logic
  always_comb begin
    logic [`OSD_CNT_W-1:0] cntInc;
    logic                  charVisible;
    logic                  redPix;
    logic                  greenPix;
    logic                  bluePix;
    logic                  lumaPix;
    logic                  blankPix;
    logic [3:0]            osdPins;
    cntInc      = s.lineCnt + 4'h1;
    charVisible = 1'b0;
    redPix      = 1'b0;
    greenPix    = 1'b0;
    bluePix     = 1'b0;
    lumaPix     = 1'b0;
    blankPix    = 1'b0;
    osdPins     = 4'h0;
    next_s      = s;
    next_s.osdIrq = 1'b0;

    // CPU register writes
    if (cpuWr) begin
      case (cpuAddr)
        `OSD_OFF_ATTR: begin
          next_s.attrReg = cpuWrData;
          if (!bankCombined) begin
            next_s.dispAddr = s.dispAddr + 9'h001;
          end
        end
        `OSD_OFF_MISC: begin
          next_s.miscReg = cpuWrData;
          next_s.dispAddr[`OSD_ADDR_W-1] = cpuWrData[`OSD_MISC_ADDR_MSB];
        end
        `OSD_OFF_CODE: begin
          next_s.codeReg  = cpuWrData;
          next_s.dispAddr = s.dispAddr + 9'h001;
        end
        `OSD_OFF_IRQ: begin
          next_s.irqCtl = cpuWrData;
        end
        `OSD_OFF_PINSEL: begin
          next_s.pinSel = cpuWrData;
        end
        `OSD_OFF_ADDR_LOW: begin
          next_s.dispAddr[7:0] = cpuWrData;
        end
        default: begin
        end
      endcase
    end

    // Registered read data
    case (cpuAddr)
      `OSD_OFF_ATTR:     next_s.cpuRdData = s.attrReg;
      `OSD_OFF_MISC:     next_s.cpuRdData = {s.miscReg[7:1], s.dispAddr[`OSD_ADDR_W-1]};
      `OSD_OFF_CODE:     next_s.cpuRdData = s.codeReg;
      `OSD_OFF_IRQ:      next_s.cpuRdData = {s.irqCtl[7:4], s.lineCnt};
      `OSD_OFF_PINSEL:   next_s.cpuRdData = s.pinSel;
      `OSD_OFF_ADDR_LOW: next_s.cpuRdData = s.dispAddr[7:0];
      default:           next_s.cpuRdData = 8'h00;
    endcase

    // Display line counter and interrupt
    if (vsFall) begin
      next_s.lineCnt = 4'h0;
      if (s.irqCtl[`OSD_IRQ_SRC] || (s.irqCtl[3:0] == 4'h0)) begin
        next_s.osdIrq = 1'b1;
      end
    end else if (hsFall && lastScanLine) begin
      next_s.lineCnt = cntInc;
      if (!s.irqCtl[`OSD_IRQ_SRC] && (cntInc == s.irqCtl[3:0])) begin
        next_s.osdIrq = 1'b1;
      end
    end

    // Character fetch stage
    next_s.dispCode = rdCode;
    next_s.attrD    = rdAttr;

    // Pixel stage
    charVisible = patternPixel && (s.dispCode != `OSD_BLANK_CODE)
                  && !(s.miscReg[`OSD_MISC_BLINK_EN] && s.attrD[`OSD_ATTR_BLINK]);
    redPix   = charVisible && s.attrD[`OSD_ATTR_RED];
    greenPix = charVisible && s.attrD[`OSD_ATTR_GREEN];
    bluePix  = charVisible && s.attrD[`OSD_ATTR_BLUE];
    lumaPix  = redPix || greenPix || bluePix || fringePixel;
    blankPix = fullRasterBlankEnable
               || (charAreaActive && (s.dispCode != `OSD_BLANK_CODE));

    osdPins[0] = redPix ^ s.irqCtl[`OSD_IRQ_RGB_INV];
    osdPins[1] = greenPix ^ s.irqCtl[`OSD_IRQ_RGB_INV];
    osdPins[2] = bluePix ^ s.irqCtl[`OSD_IRQ_RGB_INV];
    osdPins[3] = s.miscReg[`OSD_MISC_YBL_SEL]
                 ? (blankPix ^ s.irqCtl[`OSD_IRQ_BL_INV])
                 : (lumaPix ^ s.irqCtl[`OSD_IRQ_Y_INV]);

    next_s.pinOut = (s.pinSel[7:4] & osdPins) | (~s.pinSel[7:4] & portLatch);
  end

  // ==================================================
  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cpuRdData = s.cpuRdData;
  assign dispCode  = s.dispCode;
  assign pinOut    = s.pinOut;
  assign osdIrq    = s.osdIrq;
endmodule

// *** hw/osd_regs.svh ***
`ifndef OSD_REGS_SVH
`define OSD_REGS_SVH
// How it works
// - Blink master hides characters with blink attribute
// - Eight-bit code; code zero is blank
// - Three colour bits decode to eight colours
// - Line counter clears on vsync, counts lines
// - Counter value equals completed display lines
// - Source select: line match or vsync
// - Line value picks interrupt line, zero on clear
// - Route bits pick OSD or port per pin
// - Invert bits make outputs active low
// - Select drives Y or BL on pin
// - Y is OR of colour and fringe
// - BL over non-blank characters or whole page
// - Nine-bit address, MSB in misc register
// - Bank mode: separate or combined memory writes
// - Combined: attributes stored, code stores, increments
// - Separate: each write stores, address increments

// ==================================================
// Register offsets (index on the CPU register port)
`define OSD_OFF_ATTR       3'h0
`define OSD_OFF_MISC       3'h1
`define OSD_OFF_CODE       3'h2
`define OSD_OFF_IRQ        3'h3
`define OSD_OFF_PINSEL     3'h4
`define OSD_OFF_ADDR_LOW   3'h5

// ==================================================
// Field positions
`define OSD_ATTR_BLUE      0
`define OSD_ATTR_GREEN     1
`define OSD_ATTR_RED       2
`define OSD_ATTR_BLINK     3
`define OSD_MISC_ADDR_MSB  0
`define OSD_MISC_BANK      1
`define OSD_MISC_BLINK_EN  6
`define OSD_MISC_YBL_SEL   7
`define OSD_IRQ_SRC        4
`define OSD_IRQ_RGB_INV    5
`define OSD_IRQ_Y_INV      6
`define OSD_IRQ_BL_INV     7

// ==================================================
// Sizes and reset values
`define OSD_MEM_DEPTH      512
`define OSD_ADDR_W         9
`define OSD_CODE_W         8
`define OSD_ATTR_W         6
`define OSD_CNT_W          4
`define OSD_BLANK_CODE     8'h00
`define OSD_REG_RESET      8'h00
`endif

// *** hw/osd_pkg.sv ***
`include "osd_regs.svh"
package osd_pkg;
  typedef struct packed {
    logic [`OSD_MEM_DEPTH-1:0][`OSD_CODE_W-1:0] code;
    logic [`OSD_MEM_DEPTH-1:0][`OSD_ATTR_W-1:0] attr;
  } osd_mem_t;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;
    logic [1:0] fall;
  } osd_sync_t;

  typedef struct packed {
    logic [7:0]                attrReg;
    logic [7:0]                miscReg;
    logic [7:0]                codeReg;
    logic [7:0]                irqCtl;
    logic [7:0]                pinSel;
    logic [`OSD_ADDR_W-1:0]    dispAddr;
    logic [`OSD_CNT_W-1:0]     lineCnt;
    logic [`OSD_ATTR_W-1:0]    attrD;
    logic [`OSD_CODE_W-1:0]    dispCode;
    logic [7:0]                cpuRdData;
    logic                      osdIrq;
    logic [3:0]                pinOut;
  } osd_top_t;
endpackage

// *** hw/osd_edge_sync.sv ***
`timescale 1ns/1ps
module osd_edge_sync
  import osd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] syncIn_b,
  output logic      [1:0] syncFall
);
  osd_sync_t s;
  osd_sync_t next_s;

  // ==================================================
  // Two-flop synchroniser, falling edge taken after it
  always_comb begin
    next_s        = s;
    next_s.stage1 = syncIn_b;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    next_s.fall   = s.stage3 & ~s.stage2;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{stage1: 2'h3, stage2: 2'h3, stage3: 2'h3, fall: 2'h0};
    end else begin
      s <= next_s;
    end
  end

  assign syncFall = s.fall;
endmodule

// *** hw/osd_disp_mem.sv ***
`timescale 1ns/1ps
module osd_disp_mem
  import osd_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   codeWe,
  input  wire logic                   attrWe,
  input  wire logic [`OSD_ADDR_W-1:0] wrAddr,
  input  wire logic [`OSD_CODE_W-1:0] codeIn,
  input  wire logic [`OSD_ATTR_W-1:0] attrIn,
  input  wire logic [`OSD_ADDR_W-1:0] rdAddr,
  output logic      [`OSD_CODE_W-1:0] rdCode,
  output logic      [`OSD_ATTR_W-1:0] rdAttr
);
  osd_mem_t m;
  osd_mem_t next_m;

  // ==================================================
  // Flip-flop storage, one code and one attribute per cell
  always_comb begin
    next_m = m;
    if (codeWe) begin
      next_m.code[wrAddr] = codeIn;
    end
    if (attrWe) begin
      next_m.attr[wrAddr] = attrIn;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      m <= '0;
    end else begin
      m <= next_m;
    end
  end

  assign rdCode = m.code[rdAddr];
  assign rdAttr = m.attr[rdAddr];
endmodule

// *** testbench/osd_char_ctrl_chk.sv ***
`timescale 1ns/1ps
module osd_char_ctrl_chk
  import osd_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [2:0] cpuAddr,
  input wire logic       cpuWr,
  input wire logic [7:0] cpuWrData,
  input wire logic [7:0] cpuRdData,
  input wire logic       horizontalSyncIn_b,
  input wire logic       verticalSyncIn_b,
  input wire logic       fullRasterBlankEnable,
  input wire logic [3:0] portLatch,
  input wire logic [3:0] pinOut,
  input wire logic       osdIrq
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ====
  // Shadow of control bits
  logic [3:0] route;
  logic [6:0] hist;
  logic       ybl;
  logic       blInv;
  logic       src;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      route <= 4'h0;
      hist  <= 7'h00;
      ybl   <= 1'b0;
      blInv <= 1'b0;
      src   <= 1'b0;
    end else begin
      hist <= {hist[5:0], $fell(horizontalSyncIn_b) | $fell(verticalSyncIn_b)};
      if (cpuWr && cpuAddr == 3'h4) route <= cpuWrData[7:4];
      if (cpuWr && cpuAddr == 3'h1) ybl <= cpuWrData[7];
      if (cpuWr && cpuAddr == 3'h3) blInv <= cpuWrData[7];
      if (cpuWr && cpuAddr == 3'h3) src <= cpuWrData[4];
    end
  end
  AST_IRQ_PULSE: assert property (osdIrq |=> !osdIrq)
    else $error("irq longer than one cycle");
  AST_IRQ_CAUSE: assert property (osdIrq |-> |hist)
    else $error("irq without sync edge");
  AST_VD_IRQ: assert property (src && $fell(verticalSyncIn_b) |-> ##[2:6] osdIrq)
    else $error("no irq on vsync");
  AST_REG_BACK: assert property ((cpuWr && cpuAddr inside {3'h0, 3'h1, 3'h2, 3'h4}) ##1
    (!cpuWr && $stable(cpuAddr)) |=> cpuRdData == $past(cpuWrData, 2))
    else $error("register readback wrong");
  AST_IRQ_CTL_HI: assert property ((cpuWr && cpuAddr == 3'h3) ##1 (!cpuWr && cpuAddr == 3'h3)
    |=> cpuRdData[7:4] == $past(cpuWrData[7:4], 2))
    else $error("polarity bits readback wrong");
  AST_UNMAPPED: assert property (cpuAddr > 3'h5 |=> cpuRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_PORT_PASS: assert property ((route == 4'h0 && !cpuWr && $stable(portLatch)) [*3]
    |-> pinOut == portLatch)
    else $error("port contents not passed");
  AST_FULL_BL: assert property ((route[3] && ybl && fullRasterBlankEnable && !cpuWr) [*3]
    |-> pinOut[3] == !blInv)
    else $error("full raster blank level wrong");
endmodule
bind osd_char_ctrl osd_char_ctrl_chk chk (.ref_clk, .rst_b, .cpuAddr, .cpuWr, .cpuWrData, .cpuRdData,
  .horizontalSyncIn_b, .verticalSyncIn_b, .fullRasterBlankEnable, .portLatch, .pinOut, .osdIrq);

// *** testbench/osd_sync_src.sv ***
`timescale 1ns/1ps
module osd_sync_src (
  input  wire logic ref_clk,
  output logic      hSync_b,
  output logic      vSync_b,
  output logic      lastLine
);
  initial begin
    hSync_b = 1'b1;
    vSync_b = 1'b1;
    lastLine = 1'b0;
  end
  // One active-low sync pulse; last-line flag held past the edge
  task pulse(input logic vert, input logic last);
    @(posedge ref_clk);
    #2;
    lastLine = last;
    if (vert) vSync_b = 1'b0;
    else hSync_b = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2;
    vSync_b = 1'b1;
    hSync_b = 1'b1;
    repeat (6) @(posedge ref_clk);
    #2;
    lastLine = 1'b0;
  endtask
endmodule

// *** testbench/osd_char_ctrl_test.sv ***
`timescale 1ns/1ps
module osd_char_ctrl_test;
  import osd_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [2:0]  cpuAddr = 3'h0;
  logic        cpuWr = 1'b0;
  logic [7:0]  cpuWrData = 8'h00;
  logic [7:0]  cpuRdData;
  logic        hSync_b;
  logic        vSync_b;
  logic        lastLine;
  logic        frb = 1'b0;
  logic        area = 1'b1;
  logic        frg = 1'b0;
  logic [8:0]  rdAddr = 9'h000;
  logic [3:0]  port = 4'h0;
  logic [7:0]  dispCode;
  logic [3:0]  pinOut;
  logic        osdIrq;
  logic [31:0] lfsr = 32'h00013067;
  int          miscompares = 0;
  int          compares = 0;
  int          irqs = 0;
  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) irqs += (osdIrq === 1'b1);
  osd_sync_src sync (.ref_clk(ref_clk), .hSync_b(hSync_b), .vSync_b(vSync_b), .lastLine(lastLine));
  osd_char_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .cpuAddr(cpuAddr), .cpuWr(cpuWr),
    .cpuWrData(cpuWrData), .cpuRdData(cpuRdData), .horizontalSyncIn_b(hSync_b),
    .verticalSyncIn_b(vSync_b), .lastScanLine(lastLine), .fullRasterBlankEnable(frb),
    .dispRdAddr(rdAddr), .charAreaActive(area), .patternPixel(1'b1), .fringePixel(frg),
    .portLatch(port), .dispCode(dispCode), .pinOut(pinOut), .osdIrq(osdIrq));
  // ====
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [3:0] expPins(logic [7:0] c, logic [5:0] a, logic hide, logic inv);
    logic [2:0] rgb;
    rgb = (c == 8'h00 || hide) ? 3'h0 : {a[0], a[1], a[2]};
    return {|rgb, inv ? ~rgb : rgb};
  endfunction
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge ref_clk);
    #2;
    cpuAddr = a;
    cpuWrData = d;
    cpuWr = 1'b1;
    @(posedge ref_clk);
    #2;
    cpuWr = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] exp, string name);
    @(posedge ref_clk);
    #2;
    cpuAddr = a;
    @(posedge ref_clk);
    #2;
    check(name, exp, cpuRdData);
  endtask
  task automatic pix(logic [8:0] a, logic [7:0] code, logic [3:0] exp);
    @(posedge ref_clk);
    #2;
    rdAddr = a;
    repeat (2) @(posedge ref_clk);
    #2;
    check("code", code, dispCode);
    check("pins", {4'h0, exp}, {4'h0, pinOut});
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  // ====
  // Scenarios
  initial begin
    logic [8:0] base;
    logic [8:0] nb;
    logic [7:0] cd [8];
    logic [5:0] at [8];
    logic [7:0] v;
    int         n;
    repeat (8) @(posedge ref_clk);
    #2;
    rst_b = 1'b1;
    for (int i = 0; i < 5; i++) begin
      v = 8'(rnd());
      if (i != 3) begin
        wr(3'(i), v);
        rd(3'(i), v, "reg");
      end
    end
    wr(3'h3, 8'hb5);
    rd(3'h3, 8'hb0, "irqctl");
    rd(3'h6, 8'h00, "unmapped");
    rd(3'h7, 8'h00, "unmapped");
    $display("register test done");
    base = 9'(rnd());
    nb = base + 9'h008;
    wr(3'h5, base[7:0]);
    wr(3'h1, {7'h01, base[8]});
    for (int i = 0; i < 8; i++) begin
      at[i] = {2'b00, i == 5, 3'(i)};
      cd[i] = (i == 3) ? 8'h00 : {1'b1, 7'(rnd())};
      wr(3'h0, {2'b00, at[i]});
      wr(3'h2, cd[i]);
    end
    rd(3'h5, nb[7:0], "addrLow");
    rd(3'h1, {7'h01, nb[8]}, "addrHigh");
    wr(3'h4, 8'hf0);
    for (int p = 0; p < 2; p++) begin
      wr(3'h1, {1'b0, p[0], 5'h01, nb[8]});
      wr(3'h3, {2'b00, p[0], 5'h00});
      for (int i = 0; i < 8; i++) pix(base + 9'(i), cd[i], expPins(cd[i], at[i], p[0] & at[i][3], p[0]));
    end
    $display("combined write test done");
    v = {1'b1, 7'(rnd())};
    wr(3'h5, base[7:0]);
    wr(3'h1, {7'h00, base[8]});
    wr(3'h2, v);
    wr(3'h0, 8'h3e);
    wr(3'h3, 8'h00);
    rd(3'h5, base[7:0] + 8'h02, "addrSep");
    pix(base, v, expPins(v, at[0], 1'b0, 1'b0));
    pix(base + 9'h001, cd[1], expPins(cd[1], 6'h3e, 1'b0, 1'b0));
    $display("separate write test done");
    wr(3'h4, 8'h00);
    port = 4'(rnd());
    pix(base, v, port);
    wr(3'h4, 8'h80);
    wr(3'h1, 8'h80);
    frb = 1'b1;
    for (int b = 0; b < 2; b++) begin
      wr(3'h3, {b[0], 7'h00});
      pix(base, v, {~b[0], port[2:0]});
    end
    frb = 1'b0;
    wr(3'h3, 8'h00);
    pix(base, v, {1'b1, port[2:0]});
    pix(base + 9'h003, 8'h00, {1'b0, port[2:0]});
    area = 1'b0;
    pix(base, v, {1'b0, port[2:0]});
    area = 1'b1;
    wr(3'h1, 8'h00);
    frg = 1'b1;
    pix(base + 9'h003, 8'h00, {1'b1, port[2:0]});
    frg = 1'b0;
    $display("pin test done");
    wr(3'h3, 8'h02);
    sync.pulse(1'b1, 1'b0);
    n = irqs;
    sync.pulse(1'b0, 1'b1);
    sync.pulse(1'b0, 1'b0);
    sync.pulse(1'b0, 1'b1);
    rd(3'h3, 8'h02, "count");
    rd(3'h3, 8'h02, "count");
    check("irqLine", 8'h01, 8'(irqs - n));
    wr(3'h3, 8'h1f);
    sync.pulse(1'b1, 1'b0);
    wr(3'h3, 8'h00);
    sync.pulse(1'b1, 1'b0);
    rd(3'h3, 8'h00, "cleared");
    check("irqVsync", 8'h03, 8'(irqs - n));
    $display("interrupt test done");
    stop_test();
  end
endmodule
